// *** inc/rca_pkg.sv ***
// Behaviour
// - ALU works on 8-bit operands: add, subtract, shift and logic.
// - arithmetic is two's complement.
// - two-operand ops use W and a file register or a literal.
// - single-operand ops use W or a file register.
// - W is an 8-bit register with no data-memory address.
// - instructions update carry, nibble carry and zero in status.
// - subtraction: carry is byte no-borrow, nibble carry is nibble no-borrow (set when no borrow).
// - each instruction is one 14-bit word on its own program bus.
// - fetch overlaps execution; non-branch instructions take one cycle.
// - special registers, PC included, reachable directly and indirectly.
// - program memory internal, 512, 1K or 2K words of 14 bits.
// - in RC mode the clock out pin runs at a quarter of the input.
// - master clear held low resets the device.
// - input clock divided into four phases; PC increments in phase one.
// - operand read in phase two, result written in phase four.
// - a branch takes two cycles; the prefetched word is discarded.
package rca_pkg;
  localparam int DATA_W         = 8;
  localparam int INSN_W         = 14;
  localparam int PROG_WORDS_DEF = 2048;
  localparam int DMEM_WORDS     = 128;
  localparam int FILE_AW        = 7;

  localparam logic [6:0] ADDR_INDIRECT = 7'h00;
  localparam logic [6:0] ADDR_PCL      = 7'h02;
  localparam logic [6:0] ADDR_STATUS   = 7'h03;
  localparam logic [6:0] ADDR_FSR      = 7'h04;

  localparam int ST_C  = 0;
  localparam int ST_DC = 1;
  localparam int ST_Z  = 2;

  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] W_RST      = 8'h00;
  localparam logic [7:0] FSR_RST    = 8'h00;
  localparam logic [13:0] NOP_WORD  = 14'h0000;

  typedef enum logic [1:0] {
    PH1 = 2'b00,
    PH2 = 2'b01,
    PH3 = 2'b10,
    PH4 = 2'b11
  } rca_phase_t;

  // codes match the byte-op field of the instruction word
  typedef enum logic [3:0] {
    ALU_PASS_A = 4'h0,
    ALU_CLR    = 4'h1,
    ALU_SUB    = 4'h2,
    ALU_DEC    = 4'h3,
    ALU_IOR    = 4'h4,
    ALU_AND    = 4'h5,
    ALU_XOR    = 4'h6,
    ALU_ADD    = 4'h7,
    ALU_PASS_B = 4'h8,
    ALU_COM    = 4'h9,
    ALU_INC    = 4'hA,
    ALU_NOP_B  = 4'hB,
    ALU_RR     = 4'hC,
    ALU_RL     = 4'hD,
    ALU_SWAP   = 4'hE,
    ALU_NOP_F  = 4'hF
  } rca_alu_op_t;
endpackage

// *** src/rca_alu.sv ***
`timescale 1ns/1ps
`default_nettype none
module rca_alu
  import rca_pkg::*;
(
  // operation
  input  wire rca_alu_op_t  op,
  input  wire logic [7:0]   a_in,
  input  wire logic [7:0]   b_in,
  input  wire logic         carry_in,
  // result and flags
  output logic [7:0]        result,
  output logic              c_out,
  output logic              dc_out,
  output logic              z_out,
  output logic [2:0]        flag_mask
);
  logic [8:0] sum;
  logic [4:0] nib;

  always_comb begin
    sum       = 9'h000;
    nib       = 5'h00;
    result    = b_in;
    c_out     = carry_in;
    dc_out    = 1'b0;
    flag_mask = 3'b100;
    case (op)
      ALU_PASS_A: begin
        result    = a_in;
        flag_mask = 3'b000;
      end
      ALU_CLR:    result = 8'h00;
      ALU_ADD: begin
        sum       = {1'b0, b_in} + {1'b0, a_in};
        nib       = {1'b0, b_in[3:0]} + {1'b0, a_in[3:0]};
        result    = sum[7:0];
        c_out     = sum[8];
        dc_out    = nib[4];
        flag_mask = 3'b111;
      end
      ALU_SUB: begin
        // carry high means no borrow
        sum       = {1'b0, b_in} + {1'b0, ~a_in} + 9'h001;
        nib       = {1'b0, b_in[3:0]} + {1'b0, ~a_in[3:0]} + 5'h01;
        result    = sum[7:0];
        c_out     = sum[8];
        dc_out    = nib[4];
        flag_mask = 3'b111;
      end
      ALU_DEC:    result = b_in - 8'h01;
      ALU_INC:    result = b_in + 8'h01;
      ALU_IOR:    result = a_in | b_in;
      ALU_AND:    result = a_in & b_in;
      ALU_XOR:    result = a_in ^ b_in;
      ALU_COM:    result = ~b_in;
      ALU_RR: begin
        result    = {carry_in, b_in[7:1]};
        c_out     = b_in[0];
        flag_mask = 3'b001;
      end
      ALU_RL: begin
        result    = {b_in[6:0], carry_in};
        c_out     = b_in[7];
        flag_mask = 3'b001;
      end
      ALU_SWAP: begin
        result    = {b_in[3:0], b_in[7:4]};
        flag_mask = 3'b000;
      end
      // unsupported codes act as no-ops, so no flag moves
      ALU_NOP_B, ALU_NOP_F: flag_mask = 3'b000;
      default: flag_mask = 3'b100;
    endcase
    z_out = (result == 8'h00);
  end
endmodule
`default_nettype wire

// *** src/rca_core.sv ***
`timescale 1ns/1ps
`default_nettype none
module rca_core
  import rca_pkg::*;
#(
  parameter int PROG_WORDS = PROG_WORDS_DEF,
  parameter int PC_W       = $clog2(PROG_WORDS)
) (
  // clock and reset
  input  wire logic                ref_clk,
  input  wire logic                arst_n,
  // device pins
  input  wire logic                master_clear_n,
  input  wire logic                rc_mode,
  output logic                     quarter_clock_out_pin,
  // program memory load
  input  wire logic                pgm_we,
  input  wire logic [PC_W-1:0]     pgm_addr,
  input  wire logic [INSN_W-1:0]   pgm_data,
  // observation
  output logic [DATA_W-1:0]        working_reg,
  output logic [DATA_W-1:0]        status_reg,
  output logic [PC_W-1:0]          prog_counter
);
  logic [INSN_W-1:0] prog_mem [PROG_WORDS];
  logic [DATA_W-1:0] dmem [DMEM_WORDS];

  logic master_clear_n_s1, master_clear_n_s2, rc_s1, rc_s2;
  rca_phase_t        ph, next_ph;
  logic [PC_W-1:0]   pc, next_pc, fetch_addr, next_fetch_addr;
  logic [INSN_W-1:0] fetch_word, next_fetch_word, ir, next_ir;
  logic              fetch_valid, next_fetch_valid;
  logic              ir_valid, next_ir_valid;
  logic [7:0]        w, next_w, status, next_status, fsr, next_fsr;
  logic [7:0]        operand, next_operand;
  logic              clkout, next_clkout;

  logic        dm_we;
  logic [6:0]  dm_addr;
  logic [7:0]  dm_wdata, file_rd;
  logic [6:0]  ea;
  rca_alu_op_t alu_op;
  logic [7:0]  alu_b, alu_res;
  logic        alu_c, alu_dc, alu_z;
  logic [2:0]  alu_mask, fmask;
  logic        is_lit, dest_w, dest_f, branch, keep_flags, exec;

  // indirect slot resolves through the pointer register
  function automatic logic [6:0] eff_addr(input logic [6:0] f,
                                          input logic [7:0] ptr);
    eff_addr = (f == ADDR_INDIRECT) ? ptr[6:0] : f;
  endfunction

  assign ea   = eff_addr(ir[6:0], fsr);
  assign exec = (ph == PH4) && ir_valid && master_clear_n_s2;

  // file read mux: special registers over plain storage
  always_comb begin
    case (eff_addr(ir[6:0], fsr))
      ADDR_INDIRECT: file_rd = 8'h00;
      ADDR_PCL:      file_rd = fetch_addr[7:0];
      ADDR_STATUS:   file_rd = status;
      ADDR_FSR:      file_rd = fsr;
      default:       file_rd = dmem[ea];
    endcase
  end

  // instruction decode
  always_comb begin
    alu_op = ALU_NOP_F;
    is_lit = 1'b0;
    dest_w = 1'b0;
    dest_f = 1'b0;
    branch = 1'b0;
    keep_flags = 1'b0;
    case (ir[13:12])
      2'b00: begin
        alu_op = rca_alu_op_t'(ir[11:8]);
        if (ir[11:8] == 4'h0) begin
          dest_f = ir[7];
        end else if (ir[11:8] != 4'hB && ir[11:8] != 4'hF) begin
          dest_w = !ir[7];
          dest_f = ir[7];
        end
      end
      2'b11: begin
        is_lit = 1'b1;
        dest_w = 1'b1;
        case (ir[11:9])
          3'b000, 3'b001: begin
            alu_op     = ALU_PASS_B;
            keep_flags = 1'b1;
          end
          3'b100: begin
            case (ir[8])
              1'b0:    alu_op = ALU_IOR;
              default: alu_op = ALU_AND;
            endcase
          end
          3'b101: begin
            alu_op = ir[8] ? ALU_NOP_F : ALU_XOR;
            dest_w = !ir[8];
          end
          3'b110:  alu_op = ALU_SUB;
          3'b111:  alu_op = ALU_ADD;
          default: dest_w = 1'b0;
        endcase
      end
      2'b10:   branch = ir[11];
      default: alu_op = ALU_NOP_F;
    endcase
    if (dest_f && ea == ADDR_PCL) begin
      branch = 1'b1;
    end
  end

  assign alu_b = is_lit ? ir[7:0] : operand;
  assign fmask = keep_flags ? 3'b000 : alu_mask;

  rca_alu u_alu (
    .op        (alu_op),
    .a_in      (w),
    .b_in      (alu_b),
    .carry_in  (status[ST_C]),
    .result    (alu_res),
    .c_out     (alu_c),
    .dc_out    (alu_dc),
    .z_out     (alu_z),
    .flag_mask (alu_mask)
  );

  always_comb begin
    next_ph          = rca_phase_t'(2'(ph + 2'b01));
    next_pc          = pc;
    next_fetch_addr  = fetch_addr;
    next_fetch_word  = fetch_word;
    next_fetch_valid = fetch_valid;
    next_ir          = ir;
    next_ir_valid    = ir_valid;
    next_w           = w;
    next_status      = status;
    next_fsr         = fsr;
    next_operand     = operand;
    dm_we            = 1'b0;
    dm_addr          = ea;
    dm_wdata         = alu_res;
    case (ph)
      PH1: begin
        next_ir          = fetch_word;
        next_ir_valid    = fetch_valid;
        next_fetch_addr  = pc;
        next_pc          = PC_W'(pc + 1'b1);
        next_fetch_valid = 1'b1;
      end
      PH2: next_operand = file_rd;
      PH3: next_operand = operand;
      PH4: begin
        next_fetch_word = prog_mem[fetch_addr];
        if (ir_valid) begin
          if (dest_w) begin
            next_w = alu_res;
          end
          if (dest_f) begin
            case (ea)
              ADDR_STATUS: next_status = alu_res;
              ADDR_FSR:    next_fsr = alu_res;
              ADDR_PCL:    next_pc = {fetch_addr[PC_W-1:8], alu_res};
              default:     dm_we = (ea != ADDR_INDIRECT);
            endcase
          end
          // flag updates win over a direct status write
          if (fmask[0]) next_status[ST_C] = alu_c;
          if (fmask[1]) next_status[ST_DC] = alu_dc;
          if (fmask[2]) next_status[ST_Z] = alu_z;
          if (branch) begin
            if (ir[13:12] == 2'b10) begin
              next_pc = PC_W'(ir[10:0]);
            end
            // prefetched word is dropped, target fetched next
            next_fetch_valid = 1'b0;
          end
        end
      end
      default: next_ph = PH1;
    endcase
    // clock out high in phases three and four only
    next_clkout = rc_s2 && (next_ph == PH3 || next_ph == PH4);
    if (!master_clear_n_s2) begin
      next_ph          = PH1;
      next_pc          = '0;
      next_fetch_addr  = '0;
      next_fetch_word  = NOP_WORD;
      next_fetch_valid = 1'b0;
      next_ir          = NOP_WORD;
      next_ir_valid    = 1'b0;
      next_w           = W_RST;
      next_status      = STATUS_RST;
      next_fsr         = FSR_RST;
      next_operand     = 8'h00;
      next_clkout      = 1'b0;
      dm_we            = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      master_clear_n_s1     <= 1'b0;
      master_clear_n_s2     <= 1'b0;
      rc_s1       <= 1'b0;
      rc_s2       <= 1'b0;
      ph          <= PH1;
      pc          <= '0;
      fetch_addr  <= '0;
      fetch_word  <= NOP_WORD;
      fetch_valid <= 1'b0;
      ir          <= NOP_WORD;
      ir_valid    <= 1'b0;
      w           <= W_RST;
      status      <= STATUS_RST;
      fsr         <= FSR_RST;
      operand     <= 8'h00;
      clkout      <= 1'b0;
    end else begin
      master_clear_n_s1     <= master_clear_n;
      master_clear_n_s2     <= master_clear_n_s1;
      rc_s1       <= rc_mode;
      rc_s2       <= rc_s1;
      ph          <= next_ph;
      pc          <= next_pc;
      fetch_addr  <= next_fetch_addr;
      fetch_word  <= next_fetch_word;
      fetch_valid <= next_fetch_valid;
      ir          <= next_ir;
      ir_valid    <= next_ir_valid;
      w           <= next_w;
      status      <= next_status;
      fsr         <= next_fsr;
      operand     <= next_operand;
      clkout      <= next_clkout;
    end
  end

  // storage arrays carry no reset
  always_ff @(posedge ref_clk) begin
    if (pgm_we) begin
      prog_mem[pgm_addr] <= pgm_data;
    end
    if (dm_we) begin
      dmem[dm_addr] <= dm_wdata;
    end
  end

  assign quarter_clock_out_pin = clkout;
  assign working_reg           = w;
  assign status_reg            = status;
  assign prog_counter          = pc;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n || !master_clear_n_s2);

  a_phase_ring: assert property (ph == PH1 |=> ph == PH2 ##1 ph == PH3
    ##1 ph == PH4 ##1 ph == PH1) else $error("phase ring broken");
  a_pc_step: assert property (ph == PH1 |=>
    pc == PC_W'($past(pc) + 1'b1)) else $error("pc did not step");
  a_operand_read: assert property ($changed(operand) |->
    $past(ph) == PH2) else $error("operand read outside phase two");
  a_file_write: assert property (dm_we |-> ph == PH4)
    else $error("file write outside phase four");
  a_w_hold: assert property (ph != PH4 |=> $stable(w))
    else $error("working register changed early");
  a_zero_flag: assert property (exec && fmask[2] && !branch |=>
    status[ST_Z] == ($past(alu_res) == 8'h00)) else $error("zero flag");
  a_sub_borrow: assert property (exec && alu_op == ALU_SUB |=>
    status[ST_C] == ($past(alu_b) >= $past(w))) else $error("borrow");
  a_nib_borrow: assert property (exec && alu_op == ALU_SUB |=>
    status[ST_DC] == ($past(alu_b[3:0]) >= $past(w[3:0])))
    else $error("nibble borrow");
  a_add_carry: assert property (exec && alu_op == ALU_ADD |=>
    status[ST_C] == ({1'b0, $past(alu_b)} + {1'b0, $past(w)} > 9'h0FF))
    else $error("add carry");
  a_branch_flush: assert property (exec && branch |=>
    !fetch_valid ##1 !ir_valid) else $error("branch not flushed");
  a_clk_quarter: assert property (rc_s2 && ph == PH2 |=>
    quarter_clock_out_pin ##1 quarter_clock_out_pin ##1
    !quarter_clock_out_pin) else $error("quarter clock shape");
  a_master_clear_n_reset: assert property (disable iff (!arst_n)
    !master_clear_n_s2 |=> pc == '0 && !ir_valid)
    else $error("master clear ignored");

  c_sub_run: cover property (exec && alu_op == ALU_SUB);
  c_branch: cover property (exec && branch);
  c_indirect: cover property (exec && dest_f && ir[6:0] == ADDR_INDIRECT);
  c_zero: cover property (exec && fmask[2] && alu_z);
endmodule
`default_nettype wire

// *** testbench/rca_prog_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module rca_prog_model
  import rca_pkg::*;
#(
  parameter int PC_W = 9
) (
  // clock
  input  wire logic              ref_clk,
  // control
  input  wire logic              start,
  output logic                   done,
  // program load port
  output logic                   pgm_we,
  output logic [PC_W-1:0]        pgm_addr,
  output logic [INSN_W-1:0]      pgm_data
);
  localparam int N = 22;
  logic [INSN_W-1:0] image [N];
  initial begin
    image = '{14'h300F, 14'h3E01, 14'h3C10, 14'h3001, 14'h3C00,
              14'h00A0, 14'h0720, 14'h3AFE, 14'h280A, 14'h30AA,
              14'h305A, 14'h390F, 14'h0802, 14'h3096, 14'h00A1,
              14'h3021, 14'h0084, 14'h0C00, 14'h0D00, 14'h0E80,
              14'h0800, 14'h2815};
    done = 1'b0;
    pgm_we = 1'b0;
    pgm_addr = '0;
    pgm_data = '0;
    wait (start);
    // one whole word per strobe, back to back
    for (int i = 0; i < N; i++) begin
      @(negedge ref_clk);
      pgm_we = 1'b1;
      pgm_addr = PC_W'(i);
      pgm_data = image[i];
    end
    @(negedge ref_clk);
    pgm_we = 1'b0;
    // released lines never keep the last word
    pgm_data = ~pgm_data;
    pgm_addr = ~pgm_addr;
    done = 1'b1;
  end
endmodule
`default_nettype wire

// *** testbench/rca_core_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module rca_core_tb_top
  import rca_pkg::*;
();
  localparam int PCW = 9;
  localparam logic [7:0] EXP_W [21] = '{8'h0F, 8'h10, 8'h00, 8'h01,
    8'hFF, 8'hFF, 8'hFE, 8'h00, 8'h00, 8'h00, 8'h5A, 8'h0A, 8'h0D,
    8'h96, 8'h96, 8'h21, 8'h21, 8'hCB, 8'h2C, 8'h2C, 8'h69};
  localparam logic [7:0] EXP_S [21] = '{8'h00, 8'h02, 8'h07, 8'h07,
    8'h00, 8'h00, 8'h03, 8'h07, 8'h07, 8'h07, 8'h07, 8'h03, 8'h03,
    8'h03, 8'h03, 8'h03, 8'h03, 8'h02, 8'h03, 8'h03, 8'h03};
  logic              ref_clk;
  logic              arst_n;
  logic              master_clear_n;
  logic              rc_mode;
  logic              load_go;
  logic              load_done;
  logic              quarter_clock_out_pin;
  logic              pgm_we;
  logic [PCW-1:0]    pgm_addr;
  logic [PCW-1:0]    prog_counter;
  logic [INSN_W-1:0] pgm_data;
  logic [DATA_W-1:0] working_reg;
  logic [DATA_W-1:0] status_reg;
  int                fails;
  int                comparisons;
  int                cycles;

  rca_core #(.PROG_WORDS(512)) u_rca_core (
    .ref_clk(ref_clk), .arst_n(arst_n), .master_clear_n(master_clear_n),
    .rc_mode(rc_mode), .quarter_clock_out_pin(quarter_clock_out_pin),
    .pgm_we(pgm_we), .pgm_addr(pgm_addr), .pgm_data(pgm_data),
    .working_reg(working_reg), .status_reg(status_reg),
    .prog_counter(prog_counter));

  rca_prog_model #(.PC_W(PCW)) u_rca_prog_model (
    .ref_clk(ref_clk), .start(load_go), .done(load_done),
    .pgm_we(pgm_we), .pgm_addr(pgm_addr), .pgm_data(pgm_data));

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic report_and_stop;
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      fails++;
    end
  endtask

  task automatic wait_pc(input logic [PCW-1:0] t, output int n);
    n = 0;
    while (prog_counter !== t && n < 100) begin
      @(negedge ref_clk);
      n++;
    end
    if (n == 100) begin
      check(16'(prog_counter), 16'(t));
    end
  endtask

  task automatic t_reset_state;
    repeat (4) @(negedge ref_clk);
    check(16'(prog_counter), 16'h0000);
    check(16'(working_reg), 16'h0000);
    check(16'(status_reg), 16'h0000);
  endtask

  task automatic t_program_run;
    int n;
    load_go = 1'b1;
    n = 0;
    while (load_done !== 1'b1 && n < 40) begin
      @(negedge ref_clk);
      n++;
    end
    check(16'(load_done), 16'h0001);
    master_clear_n = 1'b1;
    // the goto leaves W untouched for two slots: prefetched word dropped
    // tail runs rotates and swap through the pointer register
    for (int i = 0; i < 21; i++) begin
      wait_pc(PCW'(i + 3), n);
      if (i > 0) begin
        check(16'(n), 16'h0004);
      end
      check(16'(working_reg), 16'(EXP_W[i]));
      check(16'(status_reg), 16'(EXP_S[i]));
    end
  endtask

  task automatic t_clock_out;
    logic prev;
    int n;
    prev = quarter_clock_out_pin;
    n = 0;
    @(negedge ref_clk);
    while (!(prev === 1'b0 && quarter_clock_out_pin === 1'b1) && n < 20) begin
      prev = quarter_clock_out_pin;
      @(negedge ref_clk);
      n++;
    end
    for (int i = 0; i < 7; i++) begin
      @(negedge ref_clk);
      check(16'(quarter_clock_out_pin), 16'((i + 1) % 4 < 2));
    end
    rc_mode = 1'b0;
    repeat (4) @(negedge ref_clk);
    for (int i = 0; i < 8; i++) begin
      @(negedge ref_clk);
      check(16'(quarter_clock_out_pin), 16'h0000);
    end
  endtask

  task automatic t_master_clear;
    int n;
    master_clear_n = 1'b0;
    repeat (4) @(negedge ref_clk);
    check(16'(prog_counter), 16'h0000);
    check(16'(working_reg), 16'h0000);
    check(16'(status_reg), 16'h0000);
    master_clear_n = 1'b1;
    wait_pc(PCW'(3), n);
    check(16'(working_reg), 16'h000F);
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 4000) begin
      fails++;
      report_and_stop();
    end
  end

  initial begin
    arst_n = 1'b0;
    master_clear_n = 1'b0;
    rc_mode = 1'b1;
    load_go = 1'b0;
    fails = 0;
    comparisons = 0;
    cycles = 0;
    repeat (12) @(negedge ref_clk);
    arst_n = 1'b1;
    t_reset_state();
    t_program_run();
    t_clock_out();
    t_master_clear();
    report_and_stop();
  end
endmodule
`default_nettype wire
